// file: inc/ckg_pkg.sv
// Shared constants and types for the clock generator control block
package ckg_pkg;
    localparam int OSC_CNT_W = 8;
    localparam int FREQ_CNT_W = 16;
    localparam int MUL_W = 11;
    localparam int DIV_W = 8;
    localparam int PLL_CNT_W = 6;
    localparam int SLOW_PRESCALE = 8;
    localparam int MEAS_PERIODS = 16;
    localparam logic [OSC_CNT_W-1:0] OSC_COUNT_RST = 8'h00;
    localparam logic [MUL_W-1:0] MUL_RST = 11'h000;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
    localparam logic [PLL_CNT_W-1:0] PLL_CNT_RST = 6'h3f;
    localparam logic [2:0] PRESCALE_LAST = 3'(SLOW_PRESCALE - 1);
    localparam logic [4:0] MEAS_LAST = 5'(MEAS_PERIODS);
    typedef enum logic [1:0] {
        CKG_OSC_OFF,
        CKG_OSC_START,
        CKG_OSC_STABLE,
        CKG_OSC_BYPASS
    } ckg_osc_e;
    typedef enum logic [1:0] {
        CKG_MEAS_IDLE,
        CKG_MEAS_WAIT,
        CKG_MEAS_RUN,
        CKG_MEAS_DONE
    } ckg_meas_e;
endpackage

// file: inc/ckg_edge_if.sv
// Synchronised slow and main clock edge events shared between the modules
`timescale 1ns/1ps
interface ckg_edge_if;
    logic slow_rise;
    logic slow_fall;
    logic main_rise;
    modport src (output slow_rise, output slow_fall, output main_rise);
    modport dst (input slow_rise, input slow_fall, input main_rise);
endinterface

// file: src/ckg_edge_sync.sv
// Three-stage synchronisers and edge detectors for the sampled clocks
`timescale 1ns/1ps
module ckg_edge_sync (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Sampled clock pins
    input wire logic i_slow_clock,
    input wire logic i_main_clock,
    // Edge events
    ckg_edge_if.src edges
);
    logic [2:0] slow_sync_r;
    logic [2:0] main_sync_r;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slow_sync_r <= 3'h0;
            main_sync_r <= 3'h0;
        end else begin
            slow_sync_r <= {slow_sync_r[1:0], i_slow_clock};
            main_sync_r <= {main_sync_r[1:0], i_main_clock};
        end
    end

    // Only stages two and three are compared; stage one may be metastable
    assign edges.slow_rise = slow_sync_r[1] & ~slow_sync_r[2];
    assign edges.slow_fall = ~slow_sync_r[1] & slow_sync_r[2];
    assign edges.main_rise = main_sync_r[1] & ~main_sync_r[2];
endmodule

// file: src/ckg_pll_ctrl.sv
// PLL enable, input gating and lock countdown
`timescale 1ns/1ps
module ckg_pll_ctrl
    import ckg_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Configuration
    input wire logic i_cfg_write,
    input wire logic [ckg_pkg::MUL_W-1:0] i_pll_multiplier,
    input wire logic [ckg_pkg::DIV_W-1:0] i_pll_divider,
    input wire logic [ckg_pkg::PLL_CNT_W-1:0] i_pll_settle_count,
    // Edge events
    ckg_edge_if.dst edges,
    // Status
    output logic o_pll_enable,
    output logic o_div_enable,
    output logic o_pll_lock
);
    logic [MUL_W-1:0] mul_r;
    logic [DIV_W-1:0] div_r;
    logic [PLL_CNT_W-1:0] cnt_r;
    logic counting_r;
    logic lock_r;
    logic changed;

    // Any multiplier or divider change or a re-enable restarts the lock countdown
    assign changed = i_cfg_write && ((i_pll_multiplier != mul_r) || (i_pll_divider != div_r)
        || (mul_r == MUL_RST));

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mul_r <= MUL_RST;
            div_r <= DIV_RST;
        end else if (i_cfg_write) begin
            mul_r <= i_pll_multiplier;
            div_r <= i_pll_divider;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= PLL_CNT_RST;
            counting_r <= 1'b0;
            lock_r <= 1'b0;
        end else if (i_cfg_write && (changed || !lock_r)) begin
            cnt_r <= i_pll_settle_count;
            counting_r <= 1'b1;
            lock_r <= 1'b0;
        end else if (counting_r && (mul_r != MUL_RST) && (div_r != DIV_RST)) begin
            if (cnt_r == '0) begin
                counting_r <= 1'b0;
                lock_r <= 1'b1;
            end else if (edges.slow_rise) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    // Zero divider gates both outputs low; zero multiplier powers the PLL down
    assign o_div_enable = (div_r != DIV_RST);
    assign o_pll_enable = (mul_r != MUL_RST) && (div_r != DIV_RST);
    assign o_pll_lock = lock_r && o_pll_enable;
endmodule

// file: src/ckg_clock_gen.sv
// Clock generator control: oscillator start-up, frequency meter and PLL
`timescale 1ns/1ps
module ckg_clock_gen
    import ckg_pkg::*;
#(
    parameter int FREQ_W = ckg_pkg::FREQ_CNT_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Sampled clocks
    input wire logic i_slow_clock,
    input wire logic i_main_clock,
    // Oscillator control
    input wire logic i_osc_write,
    input wire logic i_osc_enable_bit,
    input wire logic i_osc_bypass_bit,
    input wire logic [ckg_pkg::OSC_CNT_W-1:0] i_osc_startup_count,
    // PLL control
    input wire logic i_pll_write,
    input wire logic [ckg_pkg::MUL_W-1:0] i_pll_multiplier,
    input wire logic [ckg_pkg::DIV_W-1:0] i_pll_divider,
    input wire logic [ckg_pkg::PLL_CNT_W-1:0] i_pll_settle_count,
    // Oscillator status
    output logic o_osc_power_on,
    output logic o_osc_bypass,
    output logic o_osc_stable_flag,
    output logic o_main_clock_valid,
    // Frequency measurement
    output logic o_freq_measure_ready,
    output logic [FREQ_W-1:0] o_freq_measure_count,
    // PLL status
    output logic o_pll_enable,
    output logic o_div_enable,
    output logic o_pll_lock
);
    ckg_edge_if edges ();

    ckg_osc_e osc_state_r;
    ckg_meas_e meas_state_r;
    logic enable_r;
    logic bypass_r;
    logic [OSC_CNT_W-1:0] osc_cnt_r;
    logic [2:0] prescale_r;
    logic stable_r;
    logic stable_d_r;
    logic [4:0] falls_r;
    logic [FREQ_W-1:0] freq_r;
    logic ready_r;
    logic tick8;
    logic stable_rise;

    ckg_edge_sync u_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_slow_clock(i_slow_clock),
        .i_main_clock(i_main_clock),
        .edges(edges)
    );

    ckg_pll_ctrl u_pll (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_cfg_write(i_pll_write),
        .i_pll_multiplier(i_pll_multiplier),
        .i_pll_divider(i_pll_divider),
        .i_pll_settle_count(i_pll_settle_count),
        .edges(edges),
        .o_pll_enable(o_pll_enable),
        .o_div_enable(o_div_enable),
        .o_pll_lock(o_pll_lock)
    );

    // Slow clock divided by eight, as a one-cycle enable
    assign tick8 = edges.slow_rise && (prescale_r == PRESCALE_LAST);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prescale_r <= 3'h0;
        end else if (i_osc_write) begin
            prescale_r <= 3'h0;
        end else if (edges.slow_rise) begin
            prescale_r <= prescale_r + 3'h1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enable_r <= 1'b0;
            bypass_r <= 1'b0;
        end else if (i_osc_write) begin
            enable_r <= i_osc_enable_bit;
            bypass_r <= i_osc_bypass_bit;
        end
    end

    // Oscillator start-up sequencer
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_state_r <= CKG_OSC_OFF;
            osc_cnt_r <= OSC_COUNT_RST;
            stable_r <= 1'b0;
        end else if (i_osc_write) begin
            osc_cnt_r <= i_osc_startup_count;
            stable_r <= 1'b0;
            if (i_osc_bypass_bit && !i_osc_enable_bit) begin
                osc_state_r <= CKG_OSC_BYPASS;
            end else if (i_osc_enable_bit) begin
                osc_state_r <= CKG_OSC_START;
            end else begin
                osc_state_r <= CKG_OSC_OFF;
            end
        end else begin
            case (osc_state_r)
                CKG_OSC_START: begin
                    if (osc_cnt_r == '0) begin
                        osc_state_r <= CKG_OSC_STABLE;
                        stable_r <= 1'b1;
                    end else if (tick8) begin
                        osc_cnt_r <= osc_cnt_r - 1'b1;
                    end
                end
                CKG_OSC_BYPASS: begin
                    stable_r <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stable_d_r <= 1'b0;
        end else begin
            stable_d_r <= stable_r;
        end
    end

    assign stable_rise = stable_r && !stable_d_r;

    // Frequency meter: counts main rises from a slow rise to the sixteenth slow fall
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meas_state_r <= CKG_MEAS_IDLE;
            falls_r <= 5'h00;
            freq_r <= '0;
            ready_r <= 1'b0;
        end else if (!stable_r) begin
            meas_state_r <= CKG_MEAS_IDLE;
            ready_r <= 1'b0;
        end else if (stable_rise) begin
            meas_state_r <= CKG_MEAS_WAIT;
            falls_r <= 5'h00;
            freq_r <= '0;
            ready_r <= 1'b0;
        end else begin
            case (meas_state_r)
                CKG_MEAS_WAIT: begin
                    if (edges.slow_rise) begin
                        meas_state_r <= CKG_MEAS_RUN;
                    end
                end
                CKG_MEAS_RUN: begin
                    // Saturate rather than wrap on an over-fast main clock
                    if (edges.main_rise && (freq_r != '1)) begin
                        freq_r <= freq_r + 1'b1;
                    end
                    if (edges.slow_fall) begin
                        falls_r <= falls_r + 5'h01;
                        if (falls_r + 5'h01 == MEAS_LAST) begin
                            meas_state_r <= CKG_MEAS_DONE;
                            ready_r <= 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign o_osc_power_on = enable_r;
    assign o_osc_bypass = bypass_r;
    assign o_osc_stable_flag = stable_r;
    assign o_main_clock_valid = stable_r;
    assign o_freq_measure_ready = ready_r;
    assign o_freq_measure_count = freq_r;
endmodule

// file: dv/ckg_clock_gen_asserts.sv
// Port-level assertion checker for the clock generator control block
`timescale 1ns/1ps
module ckg_clock_gen_asserts
    import ckg_pkg::*;
#(
    parameter int FREQ_W = 16
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Controls
    input wire logic i_osc_write,
    input wire logic i_osc_enable_bit,
    input wire logic i_osc_bypass_bit,
    input wire logic i_pll_write,
    input wire logic [ckg_pkg::MUL_W-1:0] i_pll_multiplier,
    input wire logic [ckg_pkg::DIV_W-1:0] i_pll_divider,
    // Status
    input wire logic o_osc_power_on,
    input wire logic o_osc_stable_flag,
    input wire logic o_main_clock_valid,
    input wire logic o_freq_measure_ready,
    input wire logic [FREQ_W-1:0] o_freq_measure_count,
    input wire logic o_pll_enable,
    input wire logic o_div_enable,
    input wire logic o_pll_lock
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    property p_osc_clr;
        i_osc_write |=> !o_osc_stable_flag;
    endproperty
    a_osc_clr: assert property (p_osc_clr) else $error("stable flag kept after write");
    property p_osc_pwr;
        i_osc_write |=> o_osc_power_on == $past(i_osc_enable_bit);
    endproperty
    a_osc_pwr: assert property (p_osc_pwr) else $error("oscillator power wrong");
    property p_osc_off;
        (i_osc_write && !i_osc_enable_bit && !i_osc_bypass_bit) ##1 !i_osc_write [*3]
            |-> !o_osc_stable_flag;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("stable while oscillator off");
    property p_byp;
        (i_osc_write && i_osc_bypass_bit && !i_osc_enable_bit) ##1 !i_osc_write
            |=> o_osc_stable_flag;
    endproperty
    a_byp: assert property (p_byp) else $error("bypass not valid in time");
    // A write in the cycle before would have cleared the flag instead
    property p_valid;
        $rose(o_osc_stable_flag) |-> o_main_clock_valid && !$past(i_osc_write);
    endproperty
    a_valid: assert property (p_valid) else $error("valid differs from stable");
    // Ready must fall once the stable flag has been low for two samples
    property p_ready_drop;
        !o_osc_stable_flag ##1 !o_osc_stable_flag |-> !o_freq_measure_ready;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready kept");
    property p_ready_hold;
        o_freq_measure_ready && $past(o_freq_measure_ready) |-> $stable(o_freq_measure_count);
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("count moved");
    property p_div_en;
        i_pll_write |=> o_div_enable == ($past(i_pll_divider) != 8'h00);
    endproperty
    a_div_en: assert property (p_div_en) else $error("divider enable wrong");
    property p_pll_off;
        !o_div_enable |-> !o_pll_enable && !o_pll_lock;
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("pll active, divider off");
    property p_mul_zero;
        i_pll_write && i_pll_multiplier == 11'h000 |=> !o_pll_enable && !o_pll_lock;
    endproperty
    a_mul_zero: assert property (p_mul_zero) else $error("pll on with zero mul");
endmodule

bind ckg_clock_gen ckg_clock_gen_asserts #(.FREQ_W(FREQ_W)) u_asserts (
    .i_clock, .i_rst_n, .i_osc_write, .i_osc_enable_bit, .i_osc_bypass_bit,
    .i_pll_write, .i_pll_multiplier, .i_pll_divider, .o_osc_power_on,
    .o_osc_stable_flag, .o_main_clock_valid, .o_freq_measure_ready,
    .o_freq_measure_count, .o_pll_enable, .o_div_enable, .o_pll_lock
);

// file: dv/testbench.sv
// Self-checking bench for the clock generator control block
`timescale 1ns/1ps
module testbench;
    import ckg_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_slow_clock = 1'b0;
    logic i_main_clock = 1'b0;
    logic i_osc_write = 1'b0;
    logic i_osc_enable_bit = 1'b0;
    logic i_osc_bypass_bit = 1'b0;
    logic [OSC_CNT_W-1:0] i_osc_startup_count = 8'h00;
    logic i_pll_write = 1'b0;
    logic [MUL_W-1:0] i_pll_multiplier = 11'h000;
    logic [DIV_W-1:0] i_pll_divider = 8'h00;
    logic [PLL_CNT_W-1:0] i_pll_settle_count = 6'h00;
    logic o_osc_power_on, o_osc_bypass, o_osc_stable_flag, o_main_clock_valid;
    logic o_freq_measure_ready, o_pll_enable, o_div_enable, o_pll_lock;
    logic [15:0] o_freq_measure_count;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    ckg_clock_gen dut (
        .i_clock, .i_rst_n, .i_slow_clock, .i_main_clock, .i_osc_write,
        .i_osc_enable_bit, .i_osc_bypass_bit, .i_osc_startup_count, .i_pll_write,
        .i_pll_multiplier, .i_pll_divider, .i_pll_settle_count, .o_osc_power_on,
        .o_osc_bypass, .o_osc_stable_flag, .o_main_clock_valid, .o_freq_measure_ready,
        .o_freq_measure_count, .o_pll_enable, .o_div_enable, .o_pll_lock
    );

    always #5 i_clock = ~i_clock;
    // Slow period 20 cycles, main period 4. The window runs from a slow rise to
    // the sixteenth slow fall, 15.5 slow periods, so it holds 77 or 78 main cycles
    always #100 i_slow_clock = ~i_slow_clock;
    always #20 i_main_clock = ~i_main_clock;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Synchronisers may shift the window by one main period either way
    task automatic meas_chk();
        samples_checked++;
        if (((o_freq_measure_count >= 16'h004c) && (o_freq_measure_count <= 16'h004f)) !== 1'b1) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, o_freq_measure_count, 16'h004d);
        end
    endtask

    task automatic osc_wr(input logic en, input logic byp, input logic [7:0] cnt);
        @(negedge i_clock);
        i_osc_write = 1'b1;
        i_osc_enable_bit = en;
        i_osc_bypass_bit = byp;
        i_osc_startup_count = cnt;
        @(negedge i_clock);
        i_osc_write = 1'b0;
    endtask

    task automatic pll_wr(input logic [10:0] mul, input logic [7:0] div, input logic [5:0] cnt);
        @(negedge i_clock);
        i_pll_write = 1'b1;
        i_pll_multiplier = mul;
        i_pll_divider = div;
        i_pll_settle_count = cnt;
        @(negedge i_clock);
        i_pll_write = 1'b0;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge i_clock);
    endtask

    // Polls stable (0), ready (1) or lock (2) with a cycle limit
    task automatic wait_hi(input int sel, input int lim);
        repeat (lim) begin
            if ((sel == 0 && o_osc_stable_flag === 1'b1) || (sel == 1 && o_freq_measure_ready === 1'b1)
                || (sel == 2 && o_pll_lock === 1'b1)) break;
            @(negedge i_clock);
        end
    endtask

    task automatic results();
        $display("Checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        repeat (16) @(posedge i_clock);
        @(negedge i_clock);
        i_rst_n = 1'b1;
        chk({o_osc_power_on, o_osc_stable_flag, o_freq_measure_ready, o_pll_lock}, 16'h0000);
        chk({o_div_enable, o_pll_enable}, 16'h0000);
        $display("reset test done");
        osc_wr(1'b1, 1'b0, 8'h00);
        chk(o_osc_stable_flag, 16'h0000);
        wait_n(2);
        chk({o_osc_power_on, o_osc_stable_flag, o_main_clock_valid}, 16'h0007);
        wait_hi(1, 450);
        chk(o_freq_measure_ready, 16'h0001);
        meas_chk();
        $display("zero count start test done");
        osc_wr(1'b1, 1'b0, 8'h02);
        chk(o_osc_stable_flag, 16'h0000);
        wait_n(2);
        chk(o_freq_measure_ready, 16'h0000);
        wait_n(276);
        chk(o_osc_stable_flag, 16'h0000);
        wait_hi(0, 80);
        chk(o_osc_stable_flag, 16'h0001);
        wait_hi(1, 450);
        chk(o_freq_measure_ready, 16'h0001);
        meas_chk();
        $display("restart test done");
        osc_wr(1'b0, 1'b0, 8'h00);
        wait_n(2);
        chk({o_osc_power_on, o_osc_stable_flag, o_main_clock_valid}, 16'h0000);
        osc_wr(1'b0, 1'b1, 8'h00);
        wait_n(2);
        chk({o_osc_bypass, o_osc_stable_flag, o_osc_power_on}, 16'h0006);
        $display("oscillator off and bypass test done");
        pll_wr(11'h000, 8'h01, 6'h03);
        chk({o_div_enable, o_pll_enable, o_pll_lock}, 16'h0004);
        pll_wr(11'h7ff, 8'hff, 6'h05);
        chk(o_pll_lock, 16'h0000);
        wait_n(60);
        chk(o_pll_lock, 16'h0000);
        wait_hi(2, 80);
        chk({o_div_enable, o_pll_enable, o_pll_lock}, 16'h0007);
        pll_wr(11'h7ff, 8'hff, 6'h05);
        chk(o_pll_lock, 16'h0001);
        pll_wr(11'h003, 8'hff, 6'h01);
        chk(o_pll_lock, 16'h0000);
        wait_hi(2, 60);
        chk(o_pll_lock, 16'h0001);
        pll_wr(11'h000, 8'hff, 6'h01);
        chk({o_pll_enable, o_pll_lock}, 16'h0000);
        pll_wr(11'h003, 8'h00, 6'h01);
        wait_n(40);
        chk({o_div_enable, o_pll_enable, o_pll_lock}, 16'h0000);
        $display("pll test done");
        // Mid-run reset with a live divider and bypass must return to the off state
        pll_wr(11'h003, 8'h01, 6'h01);
        chk(o_div_enable, 16'h0001);
        i_rst_n = 1'b0;
        wait_n(2);
        i_rst_n = 1'b1;
        chk({o_div_enable, o_pll_enable, o_pll_lock, o_osc_bypass}, 16'h0000);
        chk({o_osc_power_on, o_osc_stable_flag, o_freq_measure_ready}, 16'h0000);
        wait_n(2);
        chk({o_osc_stable_flag, o_main_clock_valid}, 16'h0000);
        $display("mid-run reset test done");
        results();
    end
endmodule
